// [hdl/scrc_pkg.sv]
/*
  Constants, types and carriers shared by the system clock and reset control block.
  Assumes one system clock at the rate named below.
*/
// How it works
// - Two independent oscillators: system one at 8 MHz and a separate timer one.
// - Timer oscillator runs at 32.768 kHz, feeds the timer, ignores the divider.
// - Only the shared ce_i and rst_n_i can stop the timer oscillator; it has no enable of its own.
// - Leaving any reset, the divider stands at the 500 kHz setting.
// - A gate register holds one enable bit per peripheral or memory clock.
// - Temperature sensor gets a fixed clock; its digital interface uses the divided clock.
// - Reset sources are exactly the external pin, the watchdog and software.
// - Pin low resets the device; restart is from address zero.
// - Configuration accesses are full aligned 32-bit words; others are refused.
package scrc_pkg;
  localparam int unsigned SYS_CLK_HZ    = 40_000_000;
  localparam int unsigned SYS_OSC_HZ    = 8_000_000;
  localparam int unsigned TMR_OSC_HZ    = 32_768;
  // Timer wave toggles twice per period, so its step is doubled
  localparam int unsigned NCO_W         = 27;
  localparam int unsigned SYS_OSC_INC   = SYS_OSC_HZ;
  localparam int unsigned TMR_OSC_INC   = 2 * TMR_OSC_HZ;
  localparam int unsigned OSC_CYC       = SYS_CLK_HZ / SYS_OSC_HZ;

  localparam int unsigned DIV_W         = 3;
  localparam int unsigned PER_W         = 10;
  localparam logic [2:0]  DIV_SEL_RESET = 3'h4;   // 8 MHz / 16 = 500 kHz
  localparam logic [9:0]  PER_BASE      = 10'(OSC_CYC);

  localparam int unsigned GATE_W        = 8;
  localparam logic [7:0]  GATE_RESET    = 8'h1f;
  localparam int unsigned TEMP_GATE_BIT = 0;

  localparam int unsigned WAKE_LOW_NS   = 100_000;
  localparam int unsigned WAKE_LOW_CYC  =
    (WAKE_LOW_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WAKE_W        = 12;
  localparam logic [11:0] WAKE_LOW_CNT  = 12'(WAKE_LOW_CYC);

  localparam logic [4:0]  RST_HOLD_CYC  = 5'h10;
  localparam logic [31:0] BOOT_ADDR     = 32'h0;

  localparam logic [1:0]  SIZE_WORD     = 2'h2;
  localparam logic [1:0]  ADDR_ALIGNED  = 2'h0;
  localparam logic        CFG_TGT_DIV   = 1'h0;
  localparam logic        CFG_TGT_GATE  = 1'h1;

  typedef struct packed {
    logic        wr;
    logic        target;
    logic [1:0]  size;
    logic [1:0]  addr_lo;
    logic [31:0] data;
  } scrc_cfg_req_t;

  typedef struct packed {
    logic pin;
    logic wdt;
    logic sw;
  } scrc_rst_cause_t;
endpackage : scrc_pkg

// [hdl/scrc_nco.sv]
/*
  Fractional tick generator standing in for a free-running oscillator.
  Assumes the step is below the modulus so at most one tick per clock.
*/
`timescale 1ns/1ps
module scrc_nco #(
  parameter int unsigned INC = 1,
  parameter int unsigned MOD = 2
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  output logic      tick_o
);
  localparam logic [26:0] STEP = 27'(INC);
  localparam logic [26:0] WRAP = 27'(MOD);

  logic [26:0] acc_r;
  logic [26:0] acc_sum;

  assign acc_sum = acc_r + STEP;

  // Phase accumulator; tick on every wrap keeps the long-term rate exact
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      acc_r  <= 27'h0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (acc_sum >= WRAP) begin
        acc_r  <= acc_sum - WRAP;
        tick_o <= 1'b1;
      end else begin
        acc_r  <= acc_sum;
        tick_o <= 1'b0;
      end
    end
  end
endmodule : scrc_nco

// [hdl/scrc_top.sv]
/*
  System clock generation and reset control: oscillators, divider, clock gates,
  reset sequencing and deep power-down wake detection.
  Assumes all inputs synchronous to sys_clk_i; no software-visible bus.
*/
`timescale 1ns/1ps
module scrc_top (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      external_reset_pin_n_i,
  input  wire logic                      wdt_rst_i,
  input  wire logic                      sw_rst_i,
  input  wire scrc_pkg::scrc_cfg_req_t   cfg_i,
  output logic                           cfg_err_o,
  input  wire logic                      deep_powerdown_wake_pin_i,
  input  wire logic                      wake_en_i,
  input  wire logic                      dpd_active_i,
  output logic                           wake_o,
  output logic                           sys_osc_tick_o,
  output logic                           timer_rc_clk_o,
  output logic                           timer_tick_o,
  output logic                           sysclk_o,
  output logic                           sysclk_en_o,
  output logic [7:0]                     periph_clk_en_o,
  output logic                           temp_sense_clk_en_o,
  output logic                           temp_if_clk_en_o,
  output logic [2:0]                     div_sel_o,
  output logic [7:0]                     gate_o,
  output logic                           core_rst_n_o,
  output logic [31:0]                    boot_addr_o,
  output scrc_pkg::scrc_rst_cause_t      rst_cause_o
);
  typedef enum logic [1:0] {ST_RUN, ST_PIN, ST_HOLD} scrc_rst_st_t;

  scrc_rst_st_t rst_st_r;
  logic [4:0]   hold_cnt_r;
  logic [2:0]   div_req_r;        // Requested setting, waits for a period boundary
  logic [2:0]   div_sel_r;        // Setting in force on the divided clock
  logic [9:0]   per_cnt_r;
  logic [9:0]   per_len;
  logic         per_wrap;
  logic [7:0]   gate_r;
  logic [11:0]  wake_cnt_r;
  logic         int_rst;
  logic         cfg_ok;
  logic         sys_tick;
  logic         tmr_tick;

  // System oscillator, 8 MHz tick train
  scrc_nco #(
    .INC (scrc_pkg::SYS_OSC_INC),
    .MOD (scrc_pkg::SYS_CLK_HZ)
  ) u_sys_osc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .tick_o    (sys_tick)
  );

  // Timer oscillator, separate instance; its only enable is the shared ce_i
  scrc_nco #(
    .INC (scrc_pkg::TMR_OSC_INC),
    .MOD (scrc_pkg::SYS_CLK_HZ)
  ) u_tmr_osc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .tick_o    (tmr_tick)
  );

  assign sys_osc_tick_o = sys_tick;

  // Timer wave: toggles on each half-period tick, never touched by the divider
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      timer_rc_clk_o <= 1'b0;
      timer_tick_o   <= 1'b0;
    end else if (ce_i) begin
      if (tmr_tick) begin
        timer_rc_clk_o <= ~timer_rc_clk_o;
      end
      timer_tick_o <= tmr_tick & ~timer_rc_clk_o; // One pulse per full period
    end
  end

  // Reset sequencer: pin holds reset, watchdog and software give a fixed hold
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rst_st_r    <= ST_HOLD;
      hold_cnt_r  <= scrc_pkg::RST_HOLD_CYC;
      rst_cause_o <= '0;
    end else if (ce_i) begin
      case (rst_st_r)
        ST_RUN: begin
          if (!external_reset_pin_n_i) begin
            rst_st_r    <= ST_PIN;
            rst_cause_o <= '{pin: 1'b1, wdt: 1'b0, sw: 1'b0};
          end else if (wdt_rst_i || sw_rst_i) begin
            rst_st_r    <= ST_HOLD;
            hold_cnt_r  <= scrc_pkg::RST_HOLD_CYC;
            rst_cause_o <= '{pin: 1'b0, wdt: wdt_rst_i, sw: sw_rst_i};
          end
        end
        ST_PIN: begin
          if (external_reset_pin_n_i) begin
            rst_st_r   <= ST_HOLD;
            hold_cnt_r <= scrc_pkg::RST_HOLD_CYC;
          end
        end
        ST_HOLD: begin
          if (!external_reset_pin_n_i) begin
            rst_st_r    <= ST_PIN;
            rst_cause_o <= '{pin: 1'b1, wdt: 1'b0, sw: 1'b0};
          end else if (hold_cnt_r != 5'h0) begin
            hold_cnt_r <= hold_cnt_r - 5'h1;
          end else if (div_sel_r == scrc_pkg::DIV_SEL_RESET) begin
            rst_st_r <= ST_RUN; // Release only once boot rate is in force
          end
        end
        default: begin
          rst_st_r <= ST_HOLD;
        end
      endcase
    end
  end

  assign int_rst      = (rst_st_r != ST_RUN);
  assign core_rst_n_o = ~int_rst;
  assign boot_addr_o  = scrc_pkg::BOOT_ADDR; // Fetch restarts at zero

  // Only full words at aligned addresses reach the configuration state
  assign cfg_ok = cfg_i.wr && (cfg_i.size == scrc_pkg::SIZE_WORD)
                  && (cfg_i.addr_lo == scrc_pkg::ADDR_ALIGNED);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_err_o <= 1'b0;
    end else if (ce_i) begin
      cfg_err_o <= cfg_i.wr & ~cfg_ok & ~int_rst;
    end
  end

  // Divider request; any reset restores the boot setting
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_req_r <= scrc_pkg::DIV_SEL_RESET;
    end else if (ce_i) begin
      if (int_rst) begin
        div_req_r <= scrc_pkg::DIV_SEL_RESET;
      end else if (cfg_ok && cfg_i.target == scrc_pkg::CFG_TGT_DIV) begin
        div_req_r <= cfg_i.data[2:0];
      end
    end
  end

  // Clock gate register, written as a whole word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gate_r <= scrc_pkg::GATE_RESET;
    end else if (ce_i) begin
      if (int_rst) begin
        gate_r <= scrc_pkg::GATE_RESET;
      end else if (cfg_ok && cfg_i.target == scrc_pkg::CFG_TGT_GATE) begin
        gate_r <= cfg_i.data[7:0];
      end
    end
  end

  // Period of divided clock in system cycles: 5 << setting
  assign per_len  = scrc_pkg::PER_BASE << div_sel_r;
  assign per_wrap = (per_cnt_r == per_len - 10'h1);

  // Divider counter; a new setting is taken only at a period boundary so no
  // short high or low phase can appear on the divided clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      per_cnt_r <= 10'h0;
      div_sel_r <= scrc_pkg::DIV_SEL_RESET;
      sysclk_o  <= 1'b1; // Count zero is a high cycle, as just after a wrap
    end else if (ce_i) begin
      if (per_wrap) begin
        per_cnt_r <= 10'h0;
        div_sel_r <= div_req_r;
        sysclk_o  <= 1'b1;
      end else begin
        per_cnt_r <= per_cnt_r + 10'h1;
        sysclk_o  <= (per_cnt_r + 10'h1) < (per_len >> 1);
      end
    end
  end

  assign sysclk_en_o = ce_i & per_wrap;
  assign div_sel_o   = div_sel_r;
  assign gate_o      = gate_r;

  // Per-peripheral enables follow the divided clock and their gate bit
  for (genvar gi = 0; gi < scrc_pkg::GATE_W; gi++) begin : g_gate
    assign periph_clk_en_o[gi] = sysclk_en_o & gate_r[gi];
  end

  // Sensor core is fed from the undivided oscillator; its interface is not
  assign temp_sense_clk_en_o = ce_i & sys_tick;
  assign temp_if_clk_en_o    = periph_clk_en_o[scrc_pkg::TEMP_GATE_BIT];

  // Wake detector: low must last the full minimum time while armed; the
  // far side keeps the pin high on entry, so a stale low is not counted
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wake_cnt_r <= 12'h0;
      wake_o     <= 1'b0;
    end else if (ce_i) begin
      wake_o <= 1'b0;
      if (!(wake_en_i && dpd_active_i) || deep_powerdown_wake_pin_i) begin
        wake_cnt_r <= 12'h0;
      end else if (wake_cnt_r != scrc_pkg::WAKE_LOW_CNT) begin
        wake_cnt_r <= wake_cnt_r + 12'h1;
        wake_o     <= (wake_cnt_r == scrc_pkg::WAKE_LOW_CNT - 12'h1);
      end
    end
  end
endmodule : scrc_top

// [test/scrc_top_monitor.sv]
/* Port checker for scrc_top.
   Bound by the bench; checks pause while ce_i holds the block frozen. */
`timescale 1ns/1ps
module scrc_top_monitor (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    ce_i,
  input wire logic                    external_reset_pin_n_i,
  input wire logic                    wdt_rst_i,
  input wire logic                    sw_rst_i,
  input wire scrc_pkg::scrc_cfg_req_t cfg_i,
  input wire logic                    cfg_err_o,
  input wire logic [7:0]              gate_o,
  input wire logic                    core_rst_n_o,
  input wire logic [2:0]              div_sel_o,
  input wire logic [31:0]             boot_addr_o,
  input wire logic [7:0]              periph_clk_en_o,
  input wire logic                    sysclk_en_o,
  input wire logic                    sysclk_o,
  input wire logic                    temp_if_clk_en_o,
  input wire logic                    sys_osc_tick_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);
  logic wr_ok;
  logic bad;
  // A write counts only in run; the shape test decides refusal
  assign wr_ok = cfg_i.wr && ce_i && core_rst_n_o;
  assign bad   = (cfg_i.size != scrc_pkg::SIZE_WORD) || (cfg_i.addr_lo != scrc_pkg::ADDR_ALIGNED);
  osc_tick_a: assert property (sys_osc_tick_o |=> !sys_osc_tick_o [*4] ##1 sys_osc_tick_o)
    else $error("system tick spacing wrong");
  boot_div_a: assert property ($rose(core_rst_n_o) |-> div_sel_o == 3'h4)
    else $error("core left reset off boot rate");
  gate_wr_a: assert property (wr_ok && !bad && cfg_i.target
    |=> gate_o == $past(cfg_i.data[7:0]))
    else $error("gate write lost");
  gate_en_a: assert property (periph_clk_en_o == (gate_o & {8{sysclk_en_o}}))
    else $error("peripheral enable not gated");
  temp_if_a: assert property (temp_if_clk_en_o == periph_clk_en_o[0])
    else $error("sensor interface clock wrong");
  src_rst_a: assert property ((wdt_rst_i || sw_rst_i) && core_rst_n_o |=> !core_rst_n_o)
    else $error("reset request ignored");
  pin_rst_a: assert property (!external_reset_pin_n_i |=> !core_rst_n_o)
    else $error("pin low did not reset");
  boot_adr_a: assert property (boot_addr_o == 32'h0)
    else $error("restart address not zero");
  cfg_err_a: assert property (wr_ok && bad |=> cfg_err_o)
    else $error("bad access not refused");
  cfg_ok_a: assert property (wr_ok && !bad |=> !cfg_err_o)
    else $error("good access refused");
  // A rise only at a wrap means no cut-short high phase
  clk_rise_a: assert property ($rose(sysclk_o) && $past(rst_n_i) |-> $past(sysclk_en_o))
    else $error("divided clock glitch");
  cover property (cfg_err_o);
  cover property (div_sel_o == 3'h7);
  cover property ($fell(core_rst_n_o));
endmodule : scrc_top_monitor

// [test/scrc_top_tb.sv]
/* Self-checking bench for scrc_top: divider, gates, resets, wake.
   Needs the package and scrc_top_monitor compiled before it. */
`timescale 1ns/1ps
module scrc_top_tb;
  logic clk, rst_n, ce, pin_n, wdt, sw, wpin, wen, dpd, cerr, wake;
  logic otick, tclk, ttick, sclk, sen, tsen, tien, cr_n;
  logic [7:0] pen, gate;
  logic [2:0] dsel;
  logic [31:0] boot;
  scrc_pkg::scrc_cfg_req_t cfg;
  scrc_pkg::scrc_rst_cause_t cause;
  int errors, n_checks;

  scrc_top i_scrc_top (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .external_reset_pin_n_i(pin_n), .wdt_rst_i(wdt), .sw_rst_i(sw), .cfg_i(cfg),
    .cfg_err_o(cerr), .deep_powerdown_wake_pin_i(wpin), .wake_en_i(wen),
    .dpd_active_i(dpd), .wake_o(wake), .sys_osc_tick_o(otick), .timer_rc_clk_o(tclk),
    .timer_tick_o(ttick), .sysclk_o(sclk), .sysclk_en_o(sen), .periph_clk_en_o(pen),
    .temp_sense_clk_en_o(tsen), .temp_if_clk_en_o(tien), .div_sel_o(dsel),
    .gate_o(gate), .core_rst_n_o(cr_n), .boot_addr_o(boot), .rst_cause_o(cause));

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // One config write; returns just after the taking edge settles
  task automatic wr(logic t, logic [1:0] sz, logic [1:0] lo, logic [31:0] d);
    @(posedge clk);
    cfg <= '{wr: 1'b1, target: t, size: sz, addr_lo: lo, data: d};
    @(posedge clk);
    cfg.wr <= 1'b0;
    #1;
  endtask : wr

  // Bounded wait for the core reset to lift
  task automatic wait_core;
    for (int i = 0; i < 2000 && cr_n !== 1'b1; i++) @(posedge clk);
    #1;
  endtask : wait_core

  // Cycles up to and including the next enable pulse
  task automatic next_en(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sen !== 1'b1 && n < 700);
  endtask : next_en

  task automatic t_div;
    int n;
    for (int s = 0; s < 8; s++) begin
      wr(1'b0, 2'h2, 2'h0, 32'(s));
      for (n = 0; n < 700 && dsel !== 3'(s); n++) begin
        @(posedge clk);
        #1;
      end
      check("div_sel", 32'(dsel), 32'(s));
      next_en(n);
      next_en(n);
      check("div_period", 32'(n), 32'(scrc_pkg::OSC_CYC << s));
    end
  endtask : t_div

  task automatic t_gate;
    wr(1'b1, 2'h2, 2'h0, 32'h3);
    check("gate", 32'(gate), 32'h3);
    check("cfg_err", 32'(cerr), 32'h0);
    // Byte, halfword, then each misaligned word offset
    for (int k = 0; k < 5; k++) begin
      wr(1'b1, k < 2 ? 2'(k) : 2'h2, k < 2 ? 2'h0 : 2'(k - 1), 32'hff);
      check("cfg_err", 32'(cerr), 32'h1);
      check("gate", 32'(gate), 32'h3);
    end
  endtask : t_gate

  // Sensor enable keeps the oscillator rate whatever the divider setting is
  task automatic t_temp;
    int cnt;
    cnt = 0;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      #1;
      cnt += int'(tsen === 1'b1);
    end
    check("temp_rate", 32'(cnt), 32'(100 / scrc_pkg::OSC_CYC));
  endtask : t_temp

  // Enable low freezes every counter, silences every enable and drops writes
  task automatic t_ce;
    int         hit;
    logic [2:0] sel0;
    logic       sclk0;
    logic       otick0;
    hit = 0;
    @(posedge clk);
    ce <= 1'b0;
    #1;
    sel0   = dsel;
    sclk0  = sclk;
    otick0 = otick;
    wr(1'b1, 2'h2, 2'h0, 32'haa);
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      hit |= int'(sen !== 1'b0 || tsen !== 1'b0 || sclk !== sclk0 || otick !== otick0);
    end
    check("ce_freeze", 32'(hit), 32'h0);
    check("ce_gate", 32'(gate), 32'h3);
    check("ce_div", 32'(dsel), 32'(sel0));
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_ce

  task automatic t_rst;
    int a, b;
    a = 0;
    b = 0;
    wr(1'b0, 2'h2, 2'h0, 32'h0);
    repeat (20) @(posedge clk);
    pin_n <= 1'b0;
    // Timer must keep ticking through the reset
    for (int n = 0; n < 2600; n++) begin
      @(posedge clk);
      #1;
      if (ttick === 1'b1) begin
        a = b;
        b = n;
        check("tmr_wave", 32'(tclk), 32'h1);
      end
    end
    check("tmr_period", 32'((b - a == 1220) || (b - a == 1221)), 32'h1);
    check("core_rst", 32'(cr_n), 32'h0);
    check("cause", 32'(cause), 32'h4);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_core;
    check("boot_div", 32'(dsel), 32'h4);
    check("gate_dflt", 32'(gate), 32'(scrc_pkg::GATE_RESET));
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      wdt <= (k == 0);
      sw  <= (k == 1);
      @(posedge clk);
      wdt <= 1'b0;
      sw  <= 1'b0;
      #1;
      check("core_rst", 32'(cr_n), 32'h0);
      check("cause", 32'(cause), k == 0 ? 32'h2 : 32'h1);
      wait_core;
    end
  endtask : t_rst

  task automatic t_wake;
    int n;
    int hit;
    hit = 0;
    @(posedge clk);
    wen <= 1'b1; // Pin already high at entry
    dpd <= 1'b1;
    @(posedge clk);
    wpin <= 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      #1;
      hit |= int'(wake === 1'b1);
    end
    check("wake_early", 32'(hit), 32'h0);
    @(posedge clk);
    wpin <= 1'b1;
    @(posedge clk);
    wpin <= 1'b0;
    for (n = 0; n < 4100 && wake !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check("wake_time", 32'(n >= 3999 && n <= 4001), 32'h1);
    @(posedge clk);
    wpin <= 1'b1;
    wen  <= 1'b0;
  endtask : t_wake

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Main sequence
  initial begin
    errors = 0;
    n_checks = 0;
    {rst_n, wdt, sw, wen, dpd} = '0;
    ce = 1'b1;
    {pin_n, wpin} = 2'h3;
    cfg = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_core;
    check("core_rst", 32'(cr_n), 32'h1);
    check("boot_div", 32'(dsel), 32'h4);
    check("gate", 32'(gate), 32'h1f);
    check("boot_addr", boot, 32'h0);
    t_temp;
    t_div;
    t_temp;
    t_gate;
    t_ce;
    t_rst;
    t_wake;
    close_out;
  end

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule : scrc_top_tb

bind scrc_top scrc_top_monitor i_scrc_top_monitor (.sys_clk_i, .rst_n_i, .ce_i,
  .external_reset_pin_n_i, .wdt_rst_i, .sw_rst_i, .cfg_i, .cfg_err_o, .gate_o,
  .core_rst_n_o, .div_sel_o, .boot_addr_o, .periph_clk_en_o, .sysclk_en_o,
  .sysclk_o, .temp_if_clk_en_o, .sys_osc_tick_o);
